// File: common/cocr_pkg.sv
// constants, field layouts and carrier types of the charger option registers
// assumes a 40 MHz system clock and a two-wire management bus on pins
package cocr_pkg;

    // ----
    // bus addressing
    // ----
    localparam logic [6:0] COCR_SLAVE_ADDR_DFLT = 7'h09;
    localparam logic [7:0] COCR_CMD_OPT0        = 8'h12;
    localparam logic [7:0] COCR_CMD_OPT1        = 8'h3B;
    localparam logic [7:0] COCR_CMD_CHG_CURRENT = 8'h14;
    localparam logic [3:0] COCR_BITS_PER_BYTE   = 4'h8;
    localparam logic [1:0] COCR_WORD_BYTES      = 2'h2;

    // ----
    // reset values, write masks and fixed bits
    // ----
    localparam logic [15:0] COCR_OPT0_RST_A  = 16'hE14E;
    localparam logic [15:0] COCR_OPT0_RST_B  = 16'hE34E;
    localparam logic [15:0] COCR_OPT0_WMASK  = 16'hFFFB;
    localparam logic [15:0] COCR_OPT0_FIXED  = 16'h0004;
    localparam logic [15:0] COCR_OPT1_RST    = 16'h0211;
    localparam logic [15:0] COCR_OPT1_WMASK  = 16'h1EFF;
    localparam logic [15:0] COCR_OPT1_FIXED  = 16'h0000;

    // ----
    // analogue settings behind the fields
    // ----
    localparam logic [10:0] COCR_FREQ_KHZ_SEL0 = 11'h258; // 600
    localparam logic [10:0] COCR_FREQ_KHZ_SEL1 = 11'h320; // 800
    localparam logic [10:0] COCR_FREQ_KHZ_SEL2 = 11'h3E8; // 1000
    localparam logic [10:0] COCR_FREQ_KHZ_SEL3 = 11'h4B0; // 1200
    localparam logic [10:0] COCR_AUDIO_MIN_KHZ = 11'h028; // 40
    localparam logic [10:0] COCR_NO_MIN_KHZ    = 11'h000;
    localparam logic [8:0]  COCR_LS_OCP_MV_LO  = 9'h0AA;  // 170
    localparam logic [8:0]  COCR_LS_OCP_MV_HI  = 9'h122;  // 290
    localparam logic [8:0]  COCR_INPUT_OVERCURRENT_PROTECT_PCT      = 9'h12C;  // 300
    localparam logic [8:0]  COCR_INPUT_OVERCURRENT_PROTECT_OFF      = 9'h000;
    localparam logic [6:0]  COCR_IN_GAIN_LO    = 7'h28;   // 40x
    localparam logic [6:0]  COCR_IN_GAIN_HI    = 7'h50;   // 80x
    localparam logic [6:0]  COCR_DIS_GAIN_LO   = 7'h08;   // 8x
    localparam logic [6:0]  COCR_DIS_GAIN_HI   = 7'h10;   // 16x

    // ----
    // carrier types
    // ----
    typedef struct packed {
        logic [4:0] upper_fields;
        logic       audio_limit;
        logic [1:0] sw_freq_sel;
        logic       input_overcurrent_protect_en;
        logic       low_side_switch_ocp_hi;
        logic       learn_en;
        logic       input_current_monitor_gain_hi;
        logic       battery_current_monitor_gain_hi;
        logic       fixed_one;
        logic       input_current_regulation_en;
        logic       charge_inhibit;
    } cocr_opt0_t;

    typedef struct packed {
        logic [2:0] fixed_hi;
        logic       sense_resistor_ratio;
        logic       battery_current_monitor_en;
        logic       system_power_monitor_en;
        logic       system_power_monitor_gain;
        logic       fixed_mid;
        logic       comparator_reference_select;
        logic       comparator_output_polarity;
        logic [1:0] comparator_deglitch_select;
        logic       fet_latch_off_en;
        logic       battery_path_switch_force_off;
        logic       battery_discharge_en;
        logic       auto_wakeup_en;
    } cocr_opt1_t;

    typedef struct packed {
        logic [10:0] sw_freq_khz;
        logic [10:0] min_freq_khz;
        logic [8:0]  low_side_switch_ocp_mv;
        logic [8:0]  input_overcurrent_limit_pct;
        logic [6:0]  input_current_monitor_gain;
        logic [6:0]  battery_current_monitor_gain;
    } cocr_derived_t;

    typedef struct packed {
        logic buck_run;
        logic input_power_switch_on;
        logic reverse_blocking_switch_on;
        logic battery_path_switch_on;
        logic input_current_regulation_en;
        logic charge_enable;
    } cocr_path_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_CMD,
        ST_CMD_ACK,
        ST_WR,
        ST_WR_ACK,
        ST_RD,
        ST_RD_ACK,
        ST_RD_NEXT
    } cocr_state_t;

endpackage

// File: design/cocr_pin_sync.sv
// three-stage synchroniser for pin levels
// assumes asynchronous pins; a change is taken once stages two and three agree
`timescale 1ns/10ps
module cocr_pin_sync #(
    parameter int unsigned WIDTH = 2
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    // raw pins and settled levels
    input  wire logic [WIDTH-1:0] pin_raw,
    output logic      [WIDTH-1:0] pin_level
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] level_r;
    wire  [WIDTH-1:0] agree = ~(s2_r ^ s3_r);
    wire  [WIDTH-1:0] level_nxt = (agree & s3_r) | (~agree & level_r);

    // idle bus lines float high, so reset to ones
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s1_r    <= '1;
            s2_r    <= '1;
            s3_r    <= '1;
            level_r <= '1;
        end else begin
            s1_r    <= pin_raw;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            level_r <= level_nxt;
        end
    end

    assign pin_level = level_r;

endmodule // cocr_pin_sync

// File: design/cocr_regs.sv
// charger option registers behind a two-wire management bus slave
// assumes open-drain bus pins resolved outside; word write/read with command code
//
// Notes on behaviour
// - audio limit holds minimum frequency 40kHz
// - frequency field selects 600k/800k/1M/1.2M, variant reset
// - bit 7 enables input overcurrent at 300%
// - bit 6 picks low-side threshold 170/290mV
// - learn bit stops buck, switches on
// - clearing learn bit restarts buck converter
// - monitor gain bits 40x/80x and 8x/16x
// - bit 1 enables input current regulation
// - inhibit blocks charge; clear then command
`timescale 1ns/10ps
module cocr_regs
    import cocr_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR   = COCR_SLAVE_ADDR_DFLT,
    parameter logic       FREQ_VARIANT = 1'b0
) (
    // clock and reset
    input  wire logic    clk_sys,
    input  wire logic    nrst,
    // two-wire bus pins
    input  wire logic    scl_i,
    input  wire logic    sda_i,
    output logic         sda_o,
    output logic         sda_oe,
    // requests from the power path logic
    input  wire logic    charge_current_nonzero,
    input  wire logic    normal_switch_req,
    input  wire logic    normal_bat_switch_req,
    // settings to the converter
    output cocr_opt0_t   opt0,
    output cocr_opt1_t   opt1,
    output cocr_derived_t derived,
    output cocr_path_t   path
);

    // ----
    // helpers
    // ----
    function automatic logic [7:0] byte_of(input logic [15:0] w, input logic hi);
        byte_of = hi ? w[15:8] : w[7:0];
    endfunction

    function automatic logic [15:0] masked(input logic [15:0] w, input logic [15:0] m,
                                           input logic [15:0] f);
        masked = (w & m) | f;
    endfunction

    // ----
    // pin sampling and bus events
    // ----
    logic [1:0] pin_lvl;
    logic       scl_q_r;
    logic       sda_q_r;

    cocr_pin_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .pin_raw   ({sda_i, scl_i}),
        .pin_level (pin_lvl)
    );

    wire scl_now   = pin_lvl[0];
    wire sda_now   = pin_lvl[1];
    wire scl_rise  = scl_now & ~scl_q_r;
    wire scl_fall  = ~scl_now & scl_q_r;
    wire start_det = scl_now & scl_q_r & sda_q_r & ~sda_now;
    wire stop_det  = scl_now & scl_q_r & ~sda_q_r & sda_now;

    // ----
    // protocol state
    // ----
    cocr_state_t state_r;
    cocr_state_t state_nxt;
    logic [3:0]  bit_cnt_r;
    logic [3:0]  bit_cnt_nxt;
    logic [7:0]  shift_r;
    logic [7:0]  shift_nxt;
    logic [7:0]  cmd_r;
    logic [7:0]  cmd_nxt;
    logic        cmd_ok_r;
    logic        cmd_ok_nxt;
    logic        rw_r;
    logic        rw_nxt;
    logic [1:0]  byte_idx_r;
    logic [1:0]  byte_idx_nxt;
    logic [7:0]  wlo_r;
    logic [7:0]  wlo_nxt;
    logic [7:0]  whi_r;
    logic [7:0]  whi_nxt;
    logic [7:0]  tx_r;
    logic [7:0]  tx_nxt;
    logic        rd_hi_r;
    logic        rd_hi_nxt;
    logic        drive_r;
    logic        drive_nxt;
    logic        commit;

    logic [15:0] opt0_r;
    logic [15:0] opt0_nxt;
    logic [15:0] opt1_r;
    logic [15:0] opt1_nxt;

    wire         addr_hit  = (shift_r[7:1] == SLAVE_ADDR);
    wire         cmd_ours  = (shift_r == COCR_CMD_OPT0) || (shift_r == COCR_CMD_OPT1);
    wire         byte_done = (bit_cnt_r == COCR_BITS_PER_BYTE);
    wire [15:0]  rd_word   = (cmd_r == COCR_CMD_OPT1) ? opt1_r : opt0_r;
    wire [15:0]  wr_word   = {whi_r, wlo_r};
    wire [15:0]  opt0_rst  = FREQ_VARIANT ? COCR_OPT0_RST_B : COCR_OPT0_RST_A;
    wire [7:0]   rd_lo     = byte_of(rd_word, 1'b0);
    wire [7:0]   rd_sel    = byte_of(rd_word, rd_hi_r);

    always_comb begin
        state_nxt    = state_r;
        bit_cnt_nxt  = bit_cnt_r;
        shift_nxt    = shift_r;
        cmd_nxt      = cmd_r;
        cmd_ok_nxt   = cmd_ok_r;
        rw_nxt       = rw_r;
        byte_idx_nxt = byte_idx_r;
        wlo_nxt      = wlo_r;
        whi_nxt      = whi_r;
        tx_nxt       = tx_r;
        rd_hi_nxt    = rd_hi_r;
        drive_nxt    = drive_r;
        commit       = 1'b0;
        if (start_det) begin
            // a repeated start drops any unfinished word write
            state_nxt    = ST_ADDR;
            bit_cnt_nxt  = 4'h0;
            byte_idx_nxt = 2'h0;
            drive_nxt    = 1'b0;
        end else if (stop_det) begin
            // a stop always brings one clock rise before it
            commit    = (state_r == ST_WR) && (byte_idx_r == COCR_WORD_BYTES)
                        && (bit_cnt_r <= 4'h1);
            state_nxt = ST_IDLE;
            drive_nxt = 1'b0;
        end else begin
            case (state_r)
                ST_ADDR, ST_CMD, ST_WR: begin
                    if (scl_rise) begin
                        shift_nxt   = {shift_r[6:0], sda_now};
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        bit_cnt_nxt = 4'h0;
                        if (state_r == ST_ADDR) begin
                            // reads need a command accepted since the last write address, in this frame or an earlier one
                            if (addr_hit && (!shift_r[0] || cmd_ok_r)) begin
                                drive_nxt = 1'b1;
                                rw_nxt    = shift_r[0];
                                state_nxt = ST_ADDR_ACK;
                            end else begin
                                state_nxt = ST_IDLE;
                            end
                        end else if (state_r == ST_CMD) begin
                            cmd_nxt    = shift_r;
                            cmd_ok_nxt = cmd_ours;
                            drive_nxt  = cmd_ours;
                            state_nxt  = cmd_ours ? ST_CMD_ACK : ST_IDLE;
                        end else if (byte_idx_r < COCR_WORD_BYTES) begin
                            drive_nxt    = 1'b1;
                            wlo_nxt      = (byte_idx_r == 2'h0) ? shift_r : wlo_r;
                            whi_nxt      = (byte_idx_r == 2'h1) ? shift_r : whi_r;
                            byte_idx_nxt = byte_idx_r + 2'h1;
                            state_nxt    = ST_WR_ACK;
                        end else begin
                            // an extra byte is refused and the word discarded
                            state_nxt = ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_r) begin
                            tx_nxt    = rd_lo;
                            drive_nxt = ~rd_lo[7];
                            rd_hi_nxt = 1'b1;
                            state_nxt = ST_RD;
                        end else begin
                            drive_nxt  = 1'b0;
                            cmd_ok_nxt = 1'b0;
                            state_nxt  = ST_CMD;
                        end
                    end
                end
                ST_CMD_ACK, ST_WR_ACK: begin
                    if (scl_fall) begin
                        drive_nxt = 1'b0;
                        state_nxt = ST_WR;
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        bit_cnt_nxt = 4'h0;
                        drive_nxt   = 1'b0;
                        state_nxt   = ST_RD_ACK;
                    end else if (scl_fall) begin
                        tx_nxt    = {tx_r[6:0], 1'b0};
                        drive_nxt = ~tx_r[6];
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        state_nxt = sda_now ? ST_IDLE : ST_RD_NEXT;
                    end
                end
                ST_RD_NEXT: begin
                    if (scl_fall) begin
                        tx_nxt    = rd_sel;
                        drive_nxt = ~rd_sel[7];
                        rd_hi_nxt = ~rd_hi_r;
                        state_nxt = ST_RD;
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // ----
    // register update
    // ----
    wire sel_opt0 = commit && (cmd_r == COCR_CMD_OPT0);
    wire sel_opt1 = commit && (cmd_r == COCR_CMD_OPT1);

    assign opt0_nxt = sel_opt0 ? masked(wr_word, COCR_OPT0_WMASK, COCR_OPT0_FIXED)
                               : opt0_r;
    assign opt1_nxt = sel_opt1 ? masked(wr_word, COCR_OPT1_WMASK, COCR_OPT1_FIXED)
                               : opt1_r;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            state_r <= ST_IDLE;
            drive_r <= 1'b0;
        end else begin
            scl_q_r <= scl_now;
            sda_q_r <= sda_now;
            state_r <= state_nxt;
            drive_r <= drive_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bit_cnt_r  <= 4'h0;
            shift_r    <= 8'h00;
            cmd_r      <= 8'h00;
            cmd_ok_r   <= 1'b0;
            rw_r       <= 1'b0;
            byte_idx_r <= 2'h0;
            wlo_r      <= 8'h00;
            whi_r      <= 8'h00;
            tx_r       <= 8'h00;
            rd_hi_r    <= 1'b0;
        end else begin
            bit_cnt_r  <= bit_cnt_nxt;
            shift_r    <= shift_nxt;
            cmd_r      <= cmd_nxt;
            cmd_ok_r   <= cmd_ok_nxt;
            rw_r       <= rw_nxt;
            byte_idx_r <= byte_idx_nxt;
            wlo_r      <= wlo_nxt;
            whi_r      <= whi_nxt;
            tx_r       <= tx_nxt;
            rd_hi_r    <= rd_hi_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            opt0_r <= opt0_rst;
            opt1_r <= COCR_OPT1_RST;
        end else begin
            opt0_r <= opt0_nxt;
            opt1_r <= opt1_nxt;
        end
    end

    // ----
    // settings and power path
    // ----
    cocr_opt0_t    f0;
    cocr_derived_t derived_r;
    cocr_derived_t derived_nxt;
    cocr_path_t    path_r;
    cocr_path_t    path_nxt;

    assign f0 = cocr_opt0_t'(opt0_r);

    wire [10:0] freq_khz = (f0.sw_freq_sel == 2'h0) ? COCR_FREQ_KHZ_SEL0 :
                           (f0.sw_freq_sel == 2'h1) ? COCR_FREQ_KHZ_SEL1 :
                           (f0.sw_freq_sel == 2'h2) ? COCR_FREQ_KHZ_SEL2 :
                                                      COCR_FREQ_KHZ_SEL3;

    assign derived_nxt.sw_freq_khz  = freq_khz;
    assign derived_nxt.min_freq_khz = f0.audio_limit ? COCR_AUDIO_MIN_KHZ
                                                     : COCR_NO_MIN_KHZ;
    assign derived_nxt.input_overcurrent_limit_pct =
        f0.input_overcurrent_protect_en ? COCR_INPUT_OVERCURRENT_PROTECT_PCT : COCR_INPUT_OVERCURRENT_PROTECT_OFF;
    assign derived_nxt.low_side_switch_ocp_mv =
        f0.low_side_switch_ocp_hi ? COCR_LS_OCP_MV_HI : COCR_LS_OCP_MV_LO;
    assign derived_nxt.input_current_monitor_gain =
        f0.input_current_monitor_gain_hi ? COCR_IN_GAIN_HI : COCR_IN_GAIN_LO;
    assign derived_nxt.battery_current_monitor_gain =
        f0.battery_current_monitor_gain_hi ? COCR_DIS_GAIN_HI : COCR_DIS_GAIN_LO;

    // learn mode parks the buck and discharges the battery into the system
    assign path_nxt.buck_run                   = ~f0.learn_en;
    assign path_nxt.input_power_switch_on      = f0.learn_en | normal_switch_req;
    assign path_nxt.reverse_blocking_switch_on = f0.learn_en | normal_switch_req;
    assign path_nxt.battery_path_switch_on     = f0.learn_en | normal_bat_switch_req;
    assign path_nxt.input_current_regulation_en = f0.input_current_regulation_en;
    // a zero charge command alone must never start charging
    assign path_nxt.charge_enable = ~f0.charge_inhibit & charge_current_nonzero;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            derived_r <= '0;
            path_r    <= '0;
        end else begin
            derived_r <= derived_nxt;
            path_r    <= path_nxt;
        end
    end

    // ----
    // outputs
    // ----
    assign opt0    = f0;
    assign opt1    = cocr_opt1_t'(opt1_r);
    assign derived = derived_r;
    assign path    = path_r;
    assign sda_o   = 1'b0;
    assign sda_oe  = drive_r;

endmodule // cocr_regs

// File: dv/cocr_regs_asserts.sv
// checker for the charger option register block
// assumes a bind to cocr_regs and one clock domain
`timescale 1ns/10ps
module cocr_regs_asserts
    import cocr_pkg::*;
(
    // clock and reset
    input wire logic          clk_sys,
    input wire logic          nrst,
    // watched ports
    input wire logic          sda_o,
    input wire logic          charge_current_nonzero,
    input wire cocr_opt0_t    opt0,
    input wire cocr_opt1_t    opt1,
    input wire cocr_derived_t derived,
    input wire cocr_path_t    path
);
    logic [1:0] up_r;
    cocr_opt0_t o0_q;
    logic       nz_q;
    // skip the first edges after release, outputs lag the registers
    wire        rdy = (up_r == 2'h3);
    wire [10:0] f_exp = o0_q.sw_freq_sel[1] ?
        (o0_q.sw_freq_sel[0] ? COCR_FREQ_KHZ_SEL3 : COCR_FREQ_KHZ_SEL2) :
        (o0_q.sw_freq_sel[0] ? COCR_FREQ_KHZ_SEL1 : COCR_FREQ_KHZ_SEL0);
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) up_r <= 2'h0;
        else if (!rdy) up_r <= up_r + 2'h1;
    end
    always_ff @(posedge clk_sys) begin
        o0_q <= opt0;
        nz_q <= charge_current_nonzero;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_learn_off; o0_q.learn_en ##1 !o0_q.learn_en; endsequence
    property p_freq; rdy |-> derived.sw_freq_khz == f_exp; endproperty
    a_freq: assert property (p_freq) else $error("switching frequency wrong");
    property p_audio; rdy |-> derived.min_freq_khz == (o0_q.audio_limit ? 11'h028 : 11'h000);
    endproperty
    a_audio: assert property (p_audio) else $error("minimum frequency wrong");
    property p_input_overcurrent_protect; rdy |-> derived.input_overcurrent_limit_pct ==
        (o0_q.input_overcurrent_protect_en ? COCR_INPUT_OVERCURRENT_PROTECT_PCT : COCR_INPUT_OVERCURRENT_PROTECT_OFF); endproperty
    a_input_overcurrent_protect: assert property (p_input_overcurrent_protect) else $error("overcurrent limit wrong");
    property p_ls; rdy |-> derived.low_side_switch_ocp_mv ==
        (o0_q.low_side_switch_ocp_hi ? COCR_LS_OCP_MV_HI : COCR_LS_OCP_MV_LO); endproperty
    a_ls: assert property (p_ls) else $error("low side threshold wrong");
    property p_gain; rdy |-> derived.input_current_monitor_gain ==
        (o0_q.input_current_monitor_gain_hi ? COCR_IN_GAIN_HI : COCR_IN_GAIN_LO)
        && derived.battery_current_monitor_gain ==
        (o0_q.battery_current_monitor_gain_hi ? COCR_DIS_GAIN_HI : COCR_DIS_GAIN_LO); endproperty
    a_gain: assert property (p_gain) else $error("monitor gain wrong");
    property p_learn; rdy && o0_q.learn_en |-> !path.buck_run && path.input_power_switch_on
        && path.reverse_blocking_switch_on && path.battery_path_switch_on; endproperty
    a_learn: assert property (p_learn) else $error("learn mode path wrong");
    property p_unlearn; rdy ##0 s_learn_off |-> path.buck_run; endproperty
    a_unlearn: assert property (p_unlearn) else $error("buck not restarted");
    property p_reg; rdy |-> path.input_current_regulation_en == o0_q.input_current_regulation_en;
    endproperty
    a_reg: assert property (p_reg) else $error("regulation enable wrong");
    property p_chg; rdy |-> path.charge_enable == (!o0_q.charge_inhibit && nz_q); endproperty
    a_chg: assert property (p_chg) else $error("charge enable wrong");
    property p_fix; opt0.fixed_one && opt1.fixed_hi == 3'h0 && !opt1.fixed_mid && !sda_o;
    endproperty
    a_fix: assert property (p_fix) else $error("reserved bits wrong");
endmodule // cocr_regs_asserts

// File: dv/cocr_host_model.sv
// host on the two-wire management bus, bit-banged at 10 clocks a phase
// assumes the line has a pull-up, so a released line reads high
`timescale 1ns/10ps
module cocr_host_model
    import cocr_pkg::*;
(
    // clock
    input  wire logic clk_sys,
    // bus wires
    input  wire logic sda_oe,
    output logic      scl,
    output logic      sda
);
    logic pull = 1'b0;
    initial scl = 1'b1;
    assign sda = ~(pull | sda_oe);
    task automatic phase(input logic c, input logic p);
        repeat (10) @(posedge clk_sys);
        #1;
        scl = c;
        pull = p;
    endtask
    task automatic bit_io(input logic b, output logic r);
        phase(1'b0, pull);
        phase(1'b0, ~b);
        phase(1'b1, ~b);
        r = sda;
    endtask
    task automatic start;
        phase(1'b0, pull);
        phase(1'b0, 1'b0);
        phase(1'b1, 1'b0);
        phase(1'b1, 1'b1);
    endtask
    task automatic stop;
        phase(1'b0, pull);
        phase(1'b0, 1'b1);
        phase(1'b1, 1'b1);
        phase(1'b1, 1'b0);
    endtask
    task automatic xfer(input logic [7:0] bo, input logic ao, output logic [7:0] bi,
                        output logic ai);
        for (int i = 7; i >= 0; i--) bit_io(bo[i], bi[i]);
        bit_io(ao, ai);
    endtask
    // clearing full leaves out the high byte, an aborted word
    task automatic write_word(input logic [7:0] cmd, input logic [15:0] d, input logic full,
                              output logic acked);
        logic [7:0] rx;
        logic [3:0] a;
        start();
        xfer({COCR_SLAVE_ADDR_DFLT, 1'b0}, 1'b1, rx, a[0]);
        xfer(cmd, 1'b1, rx, a[1]);
        xfer(d[7:0], 1'b1, rx, a[2]);
        a[3] = 1'b0;
        if (full) xfer(d[15:8], 1'b1, rx, a[3]);
        stop();
        acked = (a == 4'h0);
    endtask
    task automatic read_word(input logic [7:0] cmd, output logic [15:0] d);
        logic [7:0] rx;
        logic       a;
        start();
        xfer({COCR_SLAVE_ADDR_DFLT, 1'b0}, 1'b1, rx, a);
        xfer(cmd, 1'b1, rx, a);
        start();
        xfer({COCR_SLAVE_ADDR_DFLT, 1'b1}, 1'b1, rx, a);
        xfer(8'hFF, 1'b0, d[7:0], a);
        xfer(8'hFF, 1'b1, d[15:8], a);
        stop();
    endtask
endmodule // cocr_host_model

// File: dv/tb_cocr_regs.sv
// self-checking bench for the charger option registers
// assumes the host model drives the bus; the checker is bound at the foot
`timescale 1ns/10ps
module tb_cocr_regs
    import cocr_pkg::*;
;
    localparam logic [10:0] FREQ [4] = '{COCR_FREQ_KHZ_SEL0, COCR_FREQ_KHZ_SEL1,
                                         COCR_FREQ_KHZ_SEL2, COCR_FREQ_KHZ_SEL3};
    logic          clk_sys = 1'b0;
    logic          nrst = 1'b0;
    logic          nz = 1'b0;
    logic          sw_req = 1'b0;
    logic          bat_req = 1'b0;
    logic          scl, sda, sda_o, sda_oe;
    cocr_opt0_t    opt0;
    cocr_opt1_t    opt1;
    cocr_derived_t derived;
    cocr_path_t    path;
    int            fails = 0;
    int            n_compared = 0;
    always #12.5 clk_sys = ~clk_sys;
    cocr_regs cocr_regs_inst (.clk_sys(clk_sys), .nrst(nrst), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .charge_current_nonzero(nz),
        .normal_switch_req(sw_req), .normal_bat_switch_req(bat_req), .opt0(opt0),
        .opt1(opt1), .derived(derived), .path(path));
    cocr_host_model cocr_host_model_inst (.clk_sys(clk_sys), .sda_oe(sda_oe), .scl(scl),
        .sda(sda));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] v);
        logic a;
        cocr_host_model_inst.write_word(c, v, 1'b1, a);
        repeat (10) @(posedge clk_sys);
    endtask
    task automatic drive(input logic n, input logic s, input logic b);
        @(posedge clk_sys);
        #1;
        {nz, sw_req, bat_req} = {n, s, b};
    endtask
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic t_reset;
        logic [15:0] d;
        cocr_host_model_inst.read_word(COCR_CMD_OPT0, d);
        check(d, COCR_OPT0_RST_A);
        cocr_host_model_inst.read_word(COCR_CMD_OPT1, d);
        check(d, COCR_OPT1_RST);
    endtask
    task automatic t_fields;
        logic [15:0] v, d;
        for (int k = 0; k < 4; k++) begin
            v = {5'h00, k[0], k[1:0], k[0], ~k[0], 1'b0, k[1], ~k[1], 1'b0, k[0], 1'b0};
            wr(COCR_CMD_OPT0, v);
            cocr_host_model_inst.read_word(COCR_CMD_OPT0, d);
            check(d, v | COCR_OPT0_FIXED);
            check(derived.sw_freq_khz, FREQ[k]);
            check(derived.min_freq_khz, k[0] ? 11'h028 : 11'h000);
            check(derived.input_overcurrent_limit_pct, k[0] ? 9'h12C : 9'h000);
            check(derived.low_side_switch_ocp_mv, k[0] ? 9'h0AA : 9'h122);
            check(derived.input_current_monitor_gain, k[1] ? 7'h50 : 7'h28);
            check(derived.battery_current_monitor_gain, k[1] ? 7'h08 : 7'h10);
            check(path.input_current_regulation_en, k[0]);
        end
    endtask
    task automatic t_learn;
        drive(1'b0, 1'b0, 1'b0);
        wr(COCR_CMD_OPT0, COCR_OPT0_RST_A | 16'h0020);
        check({path.buck_run, path.input_power_switch_on, path.reverse_blocking_switch_on,
               path.battery_path_switch_on}, 4'h7);
        wr(COCR_CMD_OPT0, COCR_OPT0_RST_A);
        check({path.buck_run, path.input_power_switch_on, path.reverse_blocking_switch_on,
               path.battery_path_switch_on}, 4'h8);
    endtask
    task automatic t_inhibit;
        wr(COCR_CMD_OPT0, COCR_OPT0_RST_A | 16'h0001);
        drive(1'b1, 1'b1, 1'b1);
        repeat (3) @(posedge clk_sys);
        check(path.charge_enable, 1'b0);
        wr(COCR_CMD_OPT0, COCR_OPT0_RST_A);
        check({path.charge_enable, path.input_power_switch_on,
               path.battery_path_switch_on}, 3'h7);
        drive(1'b0, 1'b0, 1'b0);
    endtask
    task automatic t_abort;
        logic a;
        cocr_host_model_inst.write_word(COCR_CMD_OPT0, 16'h0000, 1'b0, a);
        cocr_host_model_inst.write_word(COCR_CMD_CHG_CURRENT, 16'h0000, 1'b1, a);
        check(a, 1'b0);
        repeat (10) @(posedge clk_sys);
        check(opt0, COCR_OPT0_RST_A);
    endtask
    task automatic t_reserved;
        logic [15:0] d;
        wr(COCR_CMD_OPT1, 16'hFFFF);
        cocr_host_model_inst.read_word(COCR_CMD_OPT1, d);
        check(d, COCR_OPT1_WMASK);
        check(opt1, COCR_OPT1_WMASK);
    endtask
    // hang guard
    initial begin
        repeat (95000) @(posedge clk_sys);
        fails++;
        print_verdict();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        repeat (6) @(posedge clk_sys);
        t_reset();
        t_fields();
        t_learn();
        t_inhibit();
        t_abort();
        t_reserved();
        print_verdict();
    end
endmodule // tb_cocr_regs
bind cocr_regs cocr_regs_asserts cocr_regs_asserts_inst (.clk_sys(clk_sys), .nrst(nrst),
    .sda_o(sda_o), .charge_current_nonzero(charge_current_nonzero), .opt0(opt0),
    .opt1(opt1), .derived(derived), .path(path));
